// ---- hw/front_panel_control_status.v ----
// Chosen here: the APB interface to the registers and the placing of the registers.
`include "panel_consts.vh"
`default_nettype none

// Overview of operation
// - Abort pushbutton press raises an interrupt request to the local processor.
// - Abort is debounced and edge-sensitive: one press gives exactly one request.
// - Reset pushbutton press places every onboard device into reset.
// - Reset press drives backplane system reset only when board is system controller.
// - System reset comes from button, power-up, watchdog timeout or software bit.
// - Red failure indicator lights whenever a board fault is flagged.
// - Amber status indicator lights while the processor is halted.
// - Green run indicator shows any local bus master running a cycle.
// - System-controller indicator lights while acting as backplane system controller.
// - Network indicator lights while the network controller masters the local bus.
// - SCSI indicator lights while the SCSI controller masters the local bus.
// - Backplane indicator lights while mastering or being accessed on the backplane.
// - Console defaults to 9600 baud, eight bits, one stop, no parity.
module front_panel_control_status #(
    parameter [23:0] DEBOUNCE_CYC  = `DEBOUNCE_CYC,
    parameter [23:0] RST_PULSE_CYC = `RST_PULSE_CYC,
    parameter [23:0] LED_ON_CYC    = `LED_ON_CYC
) (
    // Clock and reset.
    input  wire        core_clk,
    input  wire        rst,
    // APB slave.
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Pushbuttons, low while pressed.
    input  wire        abort_btn_n,
    input  wire        reset_btn_n,
    // Board state inputs.
    input  wire        syscon_role,
    input  wire        watchdog_timeout,
    input  wire        board_fault,
    input  wire        cpu_halted,
    input  wire        local_bus_busy,
    input  wire        lan_bus_master,
    input  wire        scsi_bus_master,
    input  wire        vme_master_busy,
    input  wire        vme_slave_busy,
    input  wire        fuse_ok,
    // Interrupt and resets.
    output reg         irq,
    output reg         board_reset,
    output reg         sysreset_o,
    output reg         sysreset_oe,
    // Front-panel indicators.
    output reg         fail_led,
    output reg         stat_led,
    output wire        run_led,
    output reg         system_controller_led,
    output wire        lan_led,
    output reg         fuse_led,
    output wire        scsi_led,
    output wire        vme_led,
    // Console serial format.
    output reg  [15:0] console_baud_div,
    output reg  [3:0]  console_data_bits,
    output reg         console_two_stop,
    output reg  [1:0]  console_parity
);

    // ------------------------------------------------------------------
    // Pushbutton filtering
    // ------------------------------------------------------------------
    wire abort_clean_n;
    wire reset_clean_n;
    reg  abort_prev_n;

    bounce_filter #(.HOLD(DEBOUNCE_CYC), .IDLE_LVL(1'b1)) u_abort_filter (
        .core_clk (core_clk),
        .rst      (rst),
        .raw      (abort_btn_n),
        .clean    (abort_clean_n)
    );

    bounce_filter #(.HOLD(DEBOUNCE_CYC), .IDLE_LVL(1'b1)) u_reset_filter (
        .core_clk (core_clk),
        .rst      (rst),
        .raw      (reset_btn_n),
        .clean    (reset_clean_n)
    );

    // Only the falling edge of the filtered level counts, so holding the
    // button down does not flood the processor with requests.
    wire abort_press = abort_prev_n & ~abort_clean_n;

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
            abort_prev_n <= 1'b1;
        else
            abort_prev_n <= abort_clean_n;
    end

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    reg         soft_rst_req;
    reg         sw_fault;
    reg  [1:0]  int_status;
    reg  [1:0]  int_mask;
    reg  [31:0] next_rdata;
    reg         next_err;

    wire setup    = psel & ~penable;
    wire access   = psel & penable & pready;
    wire wr       = access & pwrite;
    wire rd_intst = access & ~pwrite & (paddr == `OFS_INT_STATUS);
    reg  [23:0] reset_cnt;
    wire pulse_on = (reset_cnt != 24'h000000);

    // Read data is chosen in the setup cycle and registered, so the
    // access phase always completes on its first cycle.
    always @*
    begin
        next_rdata = 32'h00000000;
        next_err   = 1'b0;
        case (paddr)
            `OFS_CTRL:
                next_rdata[`CTRL_SW_FAULT] = sw_fault;
            `OFS_STATUS:
            begin
                next_rdata[`ST_ABORT_HELD]   = ~abort_clean_n;
                next_rdata[`ST_RESET_HELD]   = ~reset_clean_n;
                next_rdata[`ST_RESET_ACTIVE] = pulse_on;
                next_rdata[`ST_SYSCON]       = syscon_role;
                next_rdata[`ST_HALTED]       = cpu_halted;
                next_rdata[`ST_FUSE_OK]      = fuse_ok;
                next_rdata[`ST_FAULT]        = board_fault | sw_fault;
            end
            `OFS_INT_STATUS:
                next_rdata[1:0] = int_status;
            `OFS_INT_MASK:
                next_rdata[1:0] = int_mask;
            `OFS_CONSOLE:
            begin
                next_rdata[`CON_DIV_MSB:`CON_DIV_LSB]   = console_baud_div;
                next_rdata[`CON_BITS_MSB:`CON_BITS_LSB] = console_data_bits;
                next_rdata[`CON_TWO_STOP]               = console_two_stop;
                next_rdata[`CON_PAR_MSB:`CON_PAR_LSB]   = console_parity;
            end
            default:
                next_err = 1'b1;
        endcase
    end

    // Bus answer: ready one cycle after setup, dropped after the access.
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata  <= pwrite ? 32'h00000000 : next_rdata;
            pready  <= 1'b1;
            pslverr <= next_err;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Writable control and console format registers.
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            soft_rst_req      <= 1'b0;
            sw_fault          <= 1'b0;
            int_mask          <= `INT_MASK_RST;
            console_baud_div  <= `CON_DIV_RST;
            console_data_bits <= `CON_BITS_RST;
            console_two_stop  <= 1'b0;
            console_parity    <= `CON_PAR_RST;
        end
        else
        begin
            // The soft reset bit is a one-cycle strobe; it reads back as 0.
            soft_rst_req <= wr & (paddr == `OFS_CTRL) & pwdata[`CTRL_SOFT_RST];
            if (wr && paddr == `OFS_CTRL)
                sw_fault <= pwdata[`CTRL_SW_FAULT];
            if (wr && paddr == `OFS_INT_MASK)
                int_mask <= pwdata[1:0];
            if (wr && paddr == `OFS_CONSOLE)
            begin
                console_baud_div  <= pwdata[`CON_DIV_MSB:`CON_DIV_LSB];
                console_data_bits <= pwdata[`CON_BITS_MSB:`CON_BITS_LSB];
                console_two_stop  <= pwdata[`CON_TWO_STOP];
                console_parity    <= pwdata[`CON_PAR_MSB:`CON_PAR_LSB];
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    wire [1:0] int_events = {watchdog_timeout, abort_press};

    // A read clears the status, but an event in the same cycle survives.
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            int_status <= 2'h0;
            irq        <= 1'b0;
        end
        else
        begin
            int_status <= (rd_intst ? 2'h0 : int_status) | int_events;
            irq        <= |(int_status & int_mask);
        end
    end

    // ------------------------------------------------------------------
    // Reset generation
    // ------------------------------------------------------------------
    // The counter comes out of power-up loaded, so every power-up gives
    // a full-length pulse; a held button keeps reloading it.
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
            reset_cnt <= RST_PULSE_CYC;
        else if (~reset_clean_n | watchdog_timeout | soft_rst_req)
            reset_cnt <= RST_PULSE_CYC;
        else if (pulse_on)
            reset_cnt <= reset_cnt - 24'h000001;
    end

    // Onboard reset follows every source; the backplane line is driven
    // only by the system controller, pulled low through its enable.
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            board_reset <= 1'b1;
            sysreset_o  <= 1'b0;
            sysreset_oe <= 1'b0;
        end
        else
        begin
            board_reset <= pulse_on;
            sysreset_o  <= 1'b0;
            sysreset_oe <= pulse_on & syscon_role;
        end
    end

    // ------------------------------------------------------------------
    // Indicators
    // ------------------------------------------------------------------
    // Level indicators follow their condition one cycle later.
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            fail_led              <= 1'b0;
            stat_led              <= 1'b0;
            system_controller_led <= 1'b0;
            fuse_led              <= 1'b0;
        end
        else
        begin
            fail_led              <= board_fault | sw_fault;
            stat_led              <= cpu_halted;
            system_controller_led <= syscon_role;
            fuse_led              <= fuse_ok;
        end
    end

    // Single bus cycles last tens of nanoseconds, far too short to see,
    // so activity is stretched; the output is the stretcher's own flop.
    pulse_stretch #(.HOLD(LED_ON_CYC)) u_run_led (
        .core_clk (core_clk),
        .rst      (rst),
        .act      (local_bus_busy),
        .lit      (run_led)
    );

    pulse_stretch #(.HOLD(LED_ON_CYC)) u_lan_led (
        .core_clk (core_clk),
        .rst      (rst),
        .act      (lan_bus_master),
        .lit      (lan_led)
    );

    pulse_stretch #(.HOLD(LED_ON_CYC)) u_scsi_led (
        .core_clk (core_clk),
        .rst      (rst),
        .act      (scsi_bus_master),
        .lit      (scsi_led)
    );

    pulse_stretch #(.HOLD(LED_ON_CYC)) u_vme_led (
        .core_clk (core_clk),
        .rst      (rst),
        .act      (vme_master_busy | vme_slave_busy),
        .lit      (vme_led)
    );

endmodule // front_panel_control_status

`default_nettype wire

// ---- include/panel_consts.vh ----
`ifndef PANEL_CONSTS_VH
`define PANEL_CONSTS_VH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define CLK_MHZ          100
`define CLK_HZ           100000000
// Contact bounce settling time, in microseconds.
`define DEBOUNCE_US      10000
`define DEBOUNCE_CYC     24'h0F4240
// Least length of a generated reset pulse, in microseconds.
`define RST_PULSE_US     1000
`define RST_PULSE_CYC    24'h0186A0
// Least visible on-time of an activity indicator, in microseconds.
`define LED_ON_US        50000
`define LED_ON_CYC       24'h4C4B40
`define CNT_W            24

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_CTRL         12'h000
`define OFS_STATUS       12'h004
`define OFS_INT_STATUS   12'h008
`define OFS_INT_MASK     12'h00C
`define OFS_CONSOLE      12'h010

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_SOFT_RST    0
`define CTRL_SW_FAULT    1
`define INT_ABORT        0
`define INT_WDOG         1
`define INT_W            2
`define ST_ABORT_HELD    0
`define ST_RESET_HELD    1
`define ST_RESET_ACTIVE  2
`define ST_SYSCON        3
`define ST_HALTED        4
`define ST_FUSE_OK       5
`define ST_FAULT         6
`define CON_DIV_LSB      0
`define CON_DIV_MSB      15
`define CON_BITS_LSB     16
`define CON_BITS_MSB     19
`define CON_TWO_STOP     20
`define CON_PAR_LSB      21
`define CON_PAR_MSB      22

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CON_BAUD         9600
`define CON_DIV_RST      16'h28B0
`define CON_BITS_RST     4'h8
`define CON_PAR_RST      2'h0
`define INT_MASK_RST     2'h0

`endif

// ---- hw/bounce_filter.v ----
`default_nettype none

// ----------------------------------------------------------------------
// Bounce filter: the output follows the input only after the input has
// held one level for HOLD consecutive cycles.
// ----------------------------------------------------------------------
module bounce_filter #(
    parameter [23:0] HOLD      = 24'h000010,
    parameter        IDLE_LVL  = 1'b1
) (
    // Clock and reset.
    input  wire        core_clk,
    input  wire        rst,
    // Raw and filtered level.
    input  wire        raw,
    output reg         clean
);

    reg [23:0] count;

    // Any return to the output level restarts the count, so chatter never passes.
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            count <= 24'h000000;
            clean <= IDLE_LVL;
        end
        else if (raw == clean)
        begin
            count <= 24'h000000;
        end
        else if (count >= HOLD - 24'h000001)
        begin
            count <= 24'h000000;
            clean <= raw;
        end
        else
        begin
            count <= count + 24'h000001;
        end
    end

endmodule // bounce_filter

`default_nettype wire

// ---- hw/pulse_stretch.v ----
`default_nettype none

// ----------------------------------------------------------------------
// Pulse stretcher: output is high while the input is high and for HOLD
// cycles after it falls.
// ----------------------------------------------------------------------
module pulse_stretch #(
    parameter [23:0] HOLD = 24'h000010
) (
    // Clock and reset.
    input  wire        core_clk,
    input  wire        rst,
    // Activity in, indicator out.
    input  wire        act,
    output reg         lit
);

    reg [23:0] remain;

    // Each new burst of activity restarts the hold time.
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            remain <= 24'h000000;
            lit    <= 1'b0;
        end
        else if (act)
        begin
            remain <= HOLD;
            lit    <= 1'b1;
        end
        else if (remain != 24'h000000)
        begin
            remain <= remain - 24'h000001;
            lit    <= 1'b1;
        end
        else
        begin
            lit    <= 1'b0;
        end
    end

endmodule // pulse_stretch

`default_nettype wire

// ---- testbench/local_masters.sv ----
`default_nettype none

// ----------------------------------------------------------------------
// Far side: onboard bus masters running cycles on the local bus.
// ----------------------------------------------------------------------
module local_masters (
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Command from the bench: go holds the cycle, who picks the master.
    input  wire logic       go,
    input  wire logic [1:0] who,
    // Bus ownership seen by the panel.
    output var  logic       local_bus_busy,
    output var  logic       lan_bus_master,
    output var  logic       scsi_bus_master
);
    timeunit 1ns;
    timeprecision 1ns;

    // A cycle lasts as long as go is held, so short and long cycles are both possible.
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            local_bus_busy  <= 1'b0;
            lan_bus_master  <= 1'b0;
            scsi_bus_master <= 1'b0;
        end
        else
        begin
            local_bus_busy  <= go;
            lan_bus_master  <= go && (who == 2'h1);
            scsi_bus_master <= go && (who == 2'h2);
        end
    end
endmodule // local_masters

`default_nettype wire

// ---- testbench/panel_sva.sv ----
`default_nettype none

// ----------------------------------------------------------------------
// Checker for the front-panel block.
// ----------------------------------------------------------------------
module panel_sva #(
    parameter [23:0] DEBOUNCE_CYC  = 24'h000010,
    parameter [23:0] RST_PULSE_CYC = 24'h000010,
    parameter [23:0] LED_ON_CYC    = 24'h000010
) (
    // Clock, reset and bus.
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    // Board inputs.
    input wire logic        reset_btn_n,
    input wire logic        syscon_role,
    input wire logic        watchdog_timeout,
    input wire logic        board_fault,
    input wire logic        cpu_halted,
    input wire logic        local_bus_busy,
    input wire logic        lan_bus_master,
    input wire logic        scsi_bus_master,
    input wire logic        vme_master_busy,
    input wire logic        vme_slave_busy,
    // Outputs watched.
    input wire logic        irq,
    input wire logic        board_reset,
    input wire logic        sysreset_oe,
    input wire logic        fail_led,
    input wire logic        stat_led,
    input wire logic        run_led,
    input wire logic        system_controller_led,
    input wire logic        lan_led,
    input wire logic        scsi_led,
    input wire logic        vme_led
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [24:0] idle_cnt;
    logic [24:0] low_cnt;
    logic [24:0] src_cnt;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // Cycles since bus activity, button low time, and time since the button was low or the watchdog fired.
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            idle_cnt <= '0;
            low_cnt  <= '0;
            src_cnt  <= '0;
        end
        else
        begin
            idle_cnt <= local_bus_busy ? '0 : idle_cnt + 1'b1;
            low_cnt  <= reset_btn_n ? '0 : low_cnt + 1'b1;
            src_cnt  <= (!reset_btn_n || watchdog_timeout) ? '0 : src_cnt + 1'b1;
        end
    end

    a_fail_lit: assert property (board_fault |=> fail_led)
        else $error("fail indicator dark during fault");
    a_stat_follows: assert property (1 |=> stat_led == $past(cpu_halted))
        else $error("halt indicator wrong");
    a_system_controller_led_follows: assert property (1 |=> system_controller_led == $past(syscon_role))
        else $error("system controller indicator wrong");
    a_master_leds: assert property (1 |=> (lan_led || !$past(lan_bus_master))
        && (scsi_led || !$past(scsi_bus_master)))
        else $error("master indicator dark");
    a_vme_lit: assert property ((vme_master_busy || vme_slave_busy) |=> vme_led)
        else $error("backplane indicator dark");
    a_run_hold: assert property ($fell(run_led) |-> idle_cnt >= LED_ON_CYC)
        else $error("run indicator too short");
    a_run_lit: assert property (local_bus_busy |=> run_led)
        else $error("run indicator dark");
    a_sysrst_gate: assert property (!syscon_role && !$past(syscon_role) |-> !sysreset_oe)
        else $error("backplane reset driven by non controller");
    a_btn_reset: assert property (low_cnt >= DEBOUNCE_CYC + 4 |-> board_reset)
        else $error("button held but no board reset");
    a_rst_pulse: assert property ($fell(board_reset) |-> src_cnt >= RST_PULSE_CYC - 2)
        else $error("reset pulse too short");
    a_apb_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");

    c_irq: cover property ($rose(irq));
    c_sysrst: cover property ($rose(sysreset_oe));
    c_slverr: cover property (pready && pslverr);
endmodule // panel_sva

bind front_panel_control_status panel_sva #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC),
    .RST_PULSE_CYC(RST_PULSE_CYC),
    .LED_ON_CYC   (LED_ON_CYC)
) u_sva (.*);

`default_nettype wire

// ---- testbench/test_front_panel_control_status.sv ----
`default_nettype none

module test_front_panel_control_status;
    timeunit 1ns;
    timeprecision 1ns;

    logic        core_clk, rst, psel, penable, pwrite, go;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  who, console_parity;
    logic        abort_btn_n, reset_btn_n, syscon_role, watchdog_timeout, board_fault;
    logic        cpu_halted, vme_master_busy, vme_slave_busy, fuse_ok;
    logic        local_bus_busy, lan_bus_master, scsi_bus_master, pready, pslverr;
    logic        irq, board_reset, sysreset_o, sysreset_oe, fail_led, stat_led, run_led;
    logic        system_controller_led, lan_led, fuse_led, scsi_led, vme_led;
    logic [15:0] console_baud_div;
    logic [3:0]  console_data_bits;
    logic        console_two_stop;
    int          mismatches, tests_run, cycles;

    // Short counts keep the run brief; every wait below is sized from them.
    front_panel_control_status #(
        .DEBOUNCE_CYC (24'h000008),
        .RST_PULSE_CYC(24'h000010),
        .LED_ON_CYC   (24'h000008)
    ) dut (.*);

    local_masters pm (.*);

    always #5 core_clk = ~core_clk;

    // A hang counts as a failure and still reaches the report.
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            close_out();
        end
    end

    task miss(input string m);
        mismatches++;
        $display("mismatch at %0t: %s", $time, m);
    endtask

    task chk1(input logic got, input logic exp, input string m);
        tests_run++;
        if (got !== exp) miss(m);
    endtask

    task chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) miss(m);
    endtask

    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // One APB transfer; the request is held until pready is seen high or 20 access cycles pass.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) miss("no ready");
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task t_regs;
        logic [31:0] q;
        logic        e;
        chk32({9'h000, console_parity, console_two_stop, console_data_bits,
               console_baud_div}, 32'h000828B0, "console port");
        apb(1'b0, 12'h010, 32'h0, q, e);
        chk32(q, 32'h000828B0, "console register");
        apb(1'b0, 12'h020, 32'h0, q, e);
        chk1(e, 1'b1, "unmapped not refused");
        apb(1'b1, 12'h00C, 32'h00000003, q, e);
        apb(1'b0, 12'h00C, 32'h0, q, e);
        chk32(q, 32'h00000003, "mask readback");
        $display("register test done");
    endtask

    task t_abort;
        logic [31:0] q;
        logic        e;
        abort_btn_n <= 1'b0;
        repeat (40) if (irq !== 1'b1) @(posedge core_clk);
        chk1(irq, 1'b1, "abort gave no irq");
        apb(1'b0, 12'h008, 32'h0, q, e);
        chk32(q, 32'h00000001, "abort status");
        apb(1'b0, 12'h008, 32'h0, q, e);
        chk32(q, 32'h0, "held button gave second event");
        tick(3);
        chk1(irq, 1'b0, "irq not cleared");
        abort_btn_n <= 1'b1;
        tick(20);
        // A short glitch must not pass the filter.
        abort_btn_n <= 1'b0;
        tick(3);
        abort_btn_n <= 1'b1;
        tick(20);
        apb(1'b0, 12'h008, 32'h0, q, e);
        chk32(q, 32'h0, "glitch counted");
        $display("abort test done");
    endtask

    task t_reset;
        logic [31:0] q;
        logic        e;
        for (int r = 1; r >= 0; r--)
        begin
            syscon_role <= r[0];
            reset_btn_n <= 1'b0;
            tick(14);
            chk1(board_reset, 1'b1, "button gave no reset");
            chk1(sysreset_oe, r[0], "backplane reset wrong");
            chk1(sysreset_o, 1'b0, "backplane level driven high");
            reset_btn_n <= 1'b1;
            repeat (80) if (board_reset === 1'b1) @(posedge core_clk);
            chk1(sysreset_oe, 1'b0, "backplane reset stuck");
        end
        watchdog_timeout <= 1'b1;
        tick(1);
        watchdog_timeout <= 1'b0;
        tick(3);
        chk1(board_reset, 1'b1, "watchdog gave no reset");
        repeat (80) if (board_reset === 1'b1) @(posedge core_clk);
        apb(1'b0, 12'h008, 32'h0, q, e);
        chk32(q, 32'h00000002, "watchdog status");
        apb(1'b1, 12'h000, 32'h00000001, q, e);
        tick(4);
        chk1(board_reset, 1'b1, "soft bit gave no reset");
        repeat (80) if (board_reset === 1'b1) @(posedge core_clk);
        $display("reset test done");
    endtask

    task t_leds;
        board_fault    <= 1'b1;
        cpu_halted     <= 1'b1;
        syscon_role    <= 1'b1;
        vme_slave_busy <= 1'b1;
        fuse_ok        <= 1'b1;
        tick(3);
        chk1(fail_led, 1'b1, "fail dark");
        chk1(stat_led, 1'b1, "halt dark");
        chk1(system_controller_led, 1'b1, "controller dark");
        chk1(vme_led, 1'b1, "backplane dark");
        chk1(fuse_led, 1'b1, "fuse dark");
        board_fault    <= 1'b0;
        cpu_halted     <= 1'b0;
        syscon_role    <= 1'b0;
        vme_slave_busy <= 1'b0;
        tick(3);
        chk1(stat_led, 1'b0, "halt stuck");
        chk1(system_controller_led, 1'b0, "controller stuck");
        chk1(vme_led, 1'b1, "backplane not stretched");
        tick(12);
        chk1(vme_led, 1'b0, "backplane stuck");
        // One single-cycle bus cycle per master, the second with backplane mastering too.
        for (int m = 1; m <= 2; m++)
        begin
            who             <= m[1:0];
            go              <= 1'b1;
            vme_master_busy <= m[1];
            tick(1);
            go              <= 1'b0;
            vme_master_busy <= 1'b0;
            tick(5);
            chk1(run_led, 1'b1, "run not stretched");
            chk1(lan_led, m == 1, "lan indicator");
            chk1(scsi_led, m == 2, "scsi indicator");
            tick(15);
            chk1(run_led | lan_led | scsi_led, 1'b0, "activity stuck");
        end
        $display("indicator test done");
    endtask

    task close_out;
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        {core_clk, psel, penable, pwrite, go, paddr, pwdata, who} = '0;
        {syscon_role, watchdog_timeout, board_fault, cpu_halted} = '0;
        {vme_master_busy, vme_slave_busy, fuse_ok} = '0;
        {mismatches, tests_run, cycles} = '0;
        abort_btn_n = 1'b1;
        reset_btn_n = 1'b1;
        rst = 1'b1;
        tick(10);
        rst <= 1'b0;
        tick(30);
        t_regs();
        t_abort();
        t_reset();
        t_leds();
        close_out();
    end
endmodule // test_front_panel_control_status

`default_nettype wire
